// file: shared/port_pkg.sv
package port_pkg;

  // Port geometry: ports 0..6 have latches, ports 7 and 8 are input only
  localparam int unsigned PORT_W      = 8;
  localparam int unsigned LATCH_PORTS = 7;
  localparam int unsigned ALL_PORTS   = 9;
  localparam logic [3:0]  FIRST_INPUT_ONLY = 4'h7;

  // Values after reset, and the drive of a bit with no alternate output
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam logic [7:0] PIN_IDLE    = 8'hFF;
  localparam logic [7:0] NO_ALT_OUT  = 8'hFF;

  // Machine cycle: six states of two phases each, one clock per phase
  localparam int unsigned MC_STATES     = 6;
  localparam int unsigned MC_PHASES     = 2;
  localparam int unsigned MC_CYCLES     = MC_STATES * MC_PHASES;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MC_PERIOD_NS  = MC_CYCLES * CLK_PERIOD_NS;

  // Strong pull-up on a 0-to-1 latch change lasts two oscillator periods
  localparam int unsigned PULLUP_CYCLES = 2;

  // Ports whose pins are sampled in state 5 phase 2 instead of phase 1
  localparam logic [8:0] SAMPLE_P2_MASK = 9'h008;

  // Alternate-function bit positions
  localparam int unsigned P1_CLOCK_OUT_BIT = 6;
  localparam int unsigned P3_TXD_BIT    = 1;
  localparam int unsigned P3_WR_BIT     = 6;
  localparam int unsigned P3_RD_BIT     = 7;
  localparam int unsigned P6_TXD_BIT    = 2;

  // Port operations presented by the core
  localparam logic [3:0] OP_READ_PIN   = 4'h0;
  localparam logic [3:0] OP_WRITE      = 4'h1;
  localparam logic [3:0] OP_AND        = 4'h2;
  localparam logic [3:0] OP_OR         = 4'h3;
  localparam logic [3:0] OP_XOR        = 4'h4;
  localparam logic [3:0] OP_JUMP_CLEAR = 4'h5;
  localparam logic [3:0] OP_FLIP_BIT   = 4'h6;
  localparam logic [3:0] OP_INC        = 4'h7;
  localparam logic [3:0] OP_MINUS_ONE  = 4'h8;
  localparam logic [3:0] OP_LOOP_MINUS = 4'h9;
  localparam logic [3:0] OP_CARRY_BIT  = 4'hA;
  localparam logic [3:0] OP_CLEAR_BIT  = 4'hB;
  localparam logic [3:0] OP_SET_BIT    = 4'hC;

  // Machine-cycle states
  typedef enum logic [5:0] {
    ST_S1 = 6'h01,
    ST_S2 = 6'h02,
    ST_S3 = 6'h04,
    ST_S4 = 6'h08,
    ST_S5 = 6'h10,
    ST_S6 = 6'h20
  } mc_state_t;

endpackage : port_pkg

// file: logic/pin_sampler.sv
`timescale 1ns/1ps

// Synchronises one port byte and samples it once per machine cycle
module pin_sampler (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] pin_i,
  input  wire logic       sample_i,
  output logic      [7:0] level_o,
  output logic      [7:0] edge_o
);

  logic [7:0] sync1_q;
  logic [7:0] sync2_q;

  // Two flops before anything looks at the pin
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync1_q <= port_pkg::PIN_IDLE;
      sync2_q <= port_pkg::PIN_IDLE;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // Edge is a one-clock pulse where the new sample differs from the last
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      level_o <= port_pkg::PIN_IDLE;
      edge_o  <= 8'h00;
    end else if (sample_i) begin
      level_o <= sync2_q;
      edge_o  <= sync2_q ^ level_o;
    end else begin
      edge_o  <= 8'h00;
    end
  end

  edge_from_sample_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sample_i |=> edge_o == (level_o ^ $past(level_o)))
    else $error("edge flag does not match sample change");

endmodule : pin_sampler

// file: logic/port_latch_pin_access.sv
`timescale 1ns/1ps

// Functional notes
// - Latch-altering instruction loads the latch in state six phase two of its last cycle.
// - Output buffer takes latch value only in phase one, holds through phase two.
// - A written value first shows at the pin in state one phase one next cycle.
// - Pin reads sample in state five, phase one or two per port.
// - Edge inputs sampled once per machine cycle; edge when sample differs from last.
// - Read-modify-write on a port takes the latch, then writes the result back.
// - Read-modify-write set: and, or, xor, jump-clear, complement, increment, decrement, loop, bit ops.
// - Every other port read returns the pin levels, not the latch.
// - Single-bit operations read all eight latch bits and change only the addressed one.
// - Latch view and pin view of ports 0 to 6 share one port address.
// - Ports 7 and 8 are input only; port 0 floats as an input.
// - Port 1 bits 0 to 4 carry interrupt and capture/compare channels.
// - Port 1 bits 5 to 7 carry reload trigger, clock output, count input.
// - Port 3 carries serial 0, interrupts 0 and 1, timer inputs, memory strobes.
// - Port 4 drives compare unit outputs; port 5 drives concurrent compare outputs.
// - Port 6 bits 0 to 2: conversion start, serial 1 receive and transmit.
// - Each bit is a D latch with separate latch-read and pin-read paths.
// - Alternate functions pass only while the latch holds one; zero forces low.
// - Reset loads every port latch with ones.
// - Ports 1 to 6: a 0-to-1 latch change drives strong high in state one.
module port_latch_pin_access (
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  // Core side
  input  wire logic            cpu_req_i,
  input  wire logic [3:0]      cpu_op_i,
  input  wire logic [3:0]      cpu_port_i,
  input  wire logic [2:0]      cpu_bit_i,
  input  wire logic [7:0]      cpu_operand_i,
  input  wire logic            cpu_carry_i,
  output logic      [7:0]      cpu_rdata_o,
  output logic      [5:0]      mc_state_o,
  output logic                 mc_phase2_o,
  // Pins
  input  wire logic [8:0][7:0] port_pin_i,
  output logic      [6:0][7:0] port_pin_o,
  output logic      [6:0][7:0] port_pin_oe_o,
  // Alternate outputs from peripherals
  input  wire logic            system_clock_output_i,
  input  wire logic            serial_zero_transmit_i,
  input  wire logic            ext_write_strobe_i,
  input  wire logic            ext_read_strobe_i,
  input  wire logic [7:0]      compare_unit_outputs_i,
  input  wire logic [7:0]      concurrent_compare_out_i,
  input  wire logic            serial_one_transmit_i,
  // Alternate inputs to peripherals
  output logic                 irq3_capcomp0_pin_o,
  output logic                 irq4_capcomp1_pin_o,
  output logic                 irq5_capcomp2_pin_o,
  output logic                 irq6_capcomp3_pin_o,
  output logic                 irq2_capcomp4_pin_o,
  output logic                 timer_two_reload_trigger_o,
  output logic                 timer_two_count_in_o,
  output logic                 timer_two_count_edge_o,
  output logic                 serial_zero_receive_o,
  output logic                 ext_irq_zero_o,
  output logic                 ext_irq_one_o,
  output logic                 timer_zero_count_in_o,
  output logic                 timer_zero_count_edge_o,
  output logic                 timer_one_count_in_o,
  output logic                 timer_one_count_edge_o,
  output logic                 conversion_start_in_o,
  output logic                 serial_one_receive_o
);

  port_pkg::mc_state_t state_q;
  port_pkg::mc_state_t state_d;
  logic                phase_q;
  logic [6:0][7:0]     latch_q;
  logic [6:0][7:0]     rise_q;
  logic [6:0][7:0]     alt_drv;
  logic [8:0][7:0]     samp;
  logic [8:0][7:0]     edg;
  logic [8:0]          sample_now;
  logic                load_now;
  logic                enter_p1;
  logic                enter_s2;
  logic                latch_port;
  logic                do_write;
  logic [7:0]          latch_sel;
  logic [7:0]          pin_sel;
  logic [7:0]          new_byte;
  logic [7:0]          bit_mask;

  // Operation decode
  function automatic logic op_is_rmw(input logic [3:0] op);
    op_is_rmw = (op >= port_pkg::OP_AND) && (op <= port_pkg::OP_SET_BIT);
  endfunction : op_is_rmw

  function automatic logic [7:0] bit_sel(input logic [2:0] b);
    bit_sel = 8'h01 << b;
  endfunction : bit_sel

  // New latch byte; bit operations keep the seven other bits as read
  function automatic logic [7:0] rmw_result(input logic [3:0] op, input logic [7:0] cur,
                                            input logic [7:0] opd, input logic [2:0] b,
                                            input logic carry);
    logic [7:0] m;
    m = bit_sel(b);
    case (op)
      port_pkg::OP_WRITE:      rmw_result = opd;
      port_pkg::OP_AND:        rmw_result = cur & opd;
      port_pkg::OP_OR:         rmw_result = cur | opd;
      port_pkg::OP_XOR:        rmw_result = cur ^ opd;
      port_pkg::OP_JUMP_CLEAR: rmw_result = cur & ~m;
      port_pkg::OP_FLIP_BIT:   rmw_result = cur ^ m;
      port_pkg::OP_INC:        rmw_result = cur + 8'h01;
      port_pkg::OP_MINUS_ONE:  rmw_result = cur - 8'h01;
      port_pkg::OP_LOOP_MINUS: rmw_result = cur - 8'h01;
      port_pkg::OP_CARRY_BIT:  rmw_result = carry ? (cur | m) : (cur & ~m);
      port_pkg::OP_CLEAR_BIT:  rmw_result = cur & ~m;
      port_pkg::OP_SET_BIT:    rmw_result = cur | m;
      default:                 rmw_result = cur;
    endcase
  endfunction : rmw_result

  // Sequencer steps the state after each phase 2
  always_comb begin
    unique case (state_q)
      port_pkg::ST_S1: state_d = port_pkg::ST_S2;
      port_pkg::ST_S2: state_d = port_pkg::ST_S3;
      port_pkg::ST_S3: state_d = port_pkg::ST_S4;
      port_pkg::ST_S4: state_d = port_pkg::ST_S5;
      port_pkg::ST_S5: state_d = port_pkg::ST_S6;
      port_pkg::ST_S6: state_d = port_pkg::ST_S1;
      default:         state_d = port_pkg::ST_S1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= port_pkg::ST_S1;
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
      if (phase_q) begin
        state_q <= state_d;
      end
    end
  end

  assign mc_state_o  = state_q;
  assign mc_phase2_o = phase_q;

  // Timing strobes: each names the edge that ends the current phase
  assign enter_p1 = phase_q;
  assign load_now = (state_q == port_pkg::ST_S6) && !phase_q;
  assign enter_s2 = (state_q == port_pkg::ST_S1) && phase_q;

  // Pins are sampled in state 5, at the end of phase 1 or phase 2 as chosen per port
  genvar gp;
  generate
    for (gp = 0; gp < port_pkg::ALL_PORTS; gp++) begin : g_samp
      assign sample_now[gp] = (state_q == port_pkg::ST_S5) &&
                              (phase_q == port_pkg::SAMPLE_P2_MASK[gp]);
      pin_sampler i_pin_sampler (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (port_pin_i[gp]),
        .sample_i  (sample_now[gp]),
        .level_o   (samp[gp]),
        .edge_o    (edg[gp])
      );
    end
  endgenerate

  // One port address serves both views; the operation picks the view
  assign latch_port = cpu_port_i < port_pkg::FIRST_INPUT_ONLY;
  assign latch_sel  = latch_port ? latch_q[cpu_port_i[2:0]] : port_pkg::LATCH_RESET;
  assign pin_sel    = (cpu_port_i < 4'(port_pkg::ALL_PORTS)) ? samp[cpu_port_i] : 8'h00;
  assign bit_mask   = bit_sel(cpu_bit_i);
  assign new_byte   = rmw_result(cpu_op_i, latch_sel, cpu_operand_i, cpu_bit_i, cpu_carry_i);
  assign do_write   = cpu_req_i && latch_port &&
                      (op_is_rmw(cpu_op_i) || (cpu_op_i == port_pkg::OP_WRITE));

  // Latch read for modify operations on ports 0 to 6, pin read for everything else
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cpu_rdata_o <= 8'h00;
    end else if (cpu_req_i) begin
      cpu_rdata_o <= op_is_rmw(cpu_op_i) && latch_port ? latch_sel : pin_sel;
    end
  end

  // Latch loads and 0-to-1 tracking; the pull-up marks die at the start of S2
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      latch_q <= {port_pkg::LATCH_PORTS{port_pkg::LATCH_RESET}};
      rise_q  <= '0;
    end else begin
      if (enter_s2) begin
        rise_q <= '0;
      end
      if (load_now && do_write) begin
        latch_q[cpu_port_i[2:0]] <= new_byte;
        rise_q[cpu_port_i[2:0]]  <= new_byte & ~latch_sel;
      end
    end
  end

  // Peripheral drive per pin; bits with no alternate output idle high
  assign alt_drv[0] = port_pkg::NO_ALT_OUT;
  assign alt_drv[1] = {1'b1, system_clock_output_i, 6'h3F};
  assign alt_drv[2] = port_pkg::NO_ALT_OUT;
  assign alt_drv[3] = {ext_read_strobe_i, ext_write_strobe_i, 4'hF,
                       serial_zero_transmit_i, 1'b1};
  assign alt_drv[4] = compare_unit_outputs_i;
  assign alt_drv[5] = concurrent_compare_out_i;
  assign alt_drv[6] = {5'h1F, serial_one_transmit_i, 2'h3};

  // Output buffers capture on entry to phase 1 only, so state six phase two loads show at state one phase one.
  // A latch zero wins over the peripheral and pulls the pin low.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      port_pin_o    <= '0;
      port_pin_oe_o <= '0;
    end else if (enter_p1) begin
      port_pin_o[0]    <= 8'h00;
      port_pin_oe_o[0] <= ~latch_q[0];
      for (int i = 1; i < port_pkg::LATCH_PORTS; i++) begin
        port_pin_o[i]    <= latch_q[i] & alt_drv[i];
        port_pin_oe_o[i] <= ~(latch_q[i] & alt_drv[i]) |
                            ((state_d == port_pkg::ST_S1) ? rise_q[i] : 8'h00);
      end
    end
  end

  // Peripheral inputs pass only while the latch holds one
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq3_capcomp0_pin_o        <= 1'b1;
      irq4_capcomp1_pin_o        <= 1'b1;
      irq5_capcomp2_pin_o        <= 1'b1;
      irq6_capcomp3_pin_o        <= 1'b1;
      irq2_capcomp4_pin_o        <= 1'b1;
      timer_two_reload_trigger_o <= 1'b1;
      timer_two_count_in_o       <= 1'b1;
      timer_two_count_edge_o     <= 1'b0;
      serial_zero_receive_o      <= 1'b1;
      ext_irq_zero_o             <= 1'b1;
      ext_irq_one_o              <= 1'b1;
      timer_zero_count_in_o      <= 1'b1;
      timer_zero_count_edge_o    <= 1'b0;
      timer_one_count_in_o       <= 1'b1;
      timer_one_count_edge_o     <= 1'b0;
      conversion_start_in_o      <= 1'b1;
      serial_one_receive_o       <= 1'b1;
    end else begin
      irq3_capcomp0_pin_o        <= samp[1][0] & latch_q[1][0];
      irq4_capcomp1_pin_o        <= samp[1][1] & latch_q[1][1];
      irq5_capcomp2_pin_o        <= samp[1][2] & latch_q[1][2];
      irq6_capcomp3_pin_o        <= samp[1][3] & latch_q[1][3];
      irq2_capcomp4_pin_o        <= samp[1][4] & latch_q[1][4];
      timer_two_reload_trigger_o <= samp[1][5] & latch_q[1][5];
      timer_two_count_in_o       <= samp[1][7] & latch_q[1][7];
      timer_two_count_edge_o     <= edg[1][7] & latch_q[1][7];
      serial_zero_receive_o      <= samp[3][0] & latch_q[3][0];
      ext_irq_zero_o             <= samp[3][2] & latch_q[3][2];
      ext_irq_one_o              <= samp[3][3] & latch_q[3][3];
      timer_zero_count_in_o      <= samp[3][4] & latch_q[3][4];
      timer_zero_count_edge_o    <= edg[3][4] & latch_q[3][4];
      timer_one_count_in_o       <= samp[3][5] & latch_q[3][5];
      timer_one_count_edge_o     <= edg[3][5] & latch_q[3][5];
      conversion_start_in_o      <= samp[6][0] & latch_q[6][0];
      serial_one_receive_o       <= samp[6][1] & latch_q[6][1];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s6_end_s;
    (state_q == port_pkg::ST_S6) && phase_q;
  endsequence

  sequence rise_on_p2_s;
    load_now && do_write && (cpu_port_i == 4'h2) && !latch_q[2][1] && new_byte[1];
  endsequence

  cycle_order_a: assert property (s6_end_s |=> (state_q == port_pkg::ST_S1) && !phase_q)
    else $error("machine cycle did not wrap to state one phase one");
  latch_load_a: assert property (load_now && do_write |=>
    (state_q == port_pkg::ST_S6) && phase_q && latch_q[$past(cpu_port_i[2:0])] == $past(new_byte))
    else $error("latch not loaded in state six phase two");
  latch_quiet_a: assert property (!load_now |=> $stable(latch_q))
    else $error("latch changed outside its load slot");
  buffer_hold_a: assert property (!phase_q |=> $stable(port_pin_o) && $stable(port_pin_oe_o))
    else $error("output buffer changed in phase two");
  pin_appear_a: assert property (s6_end_s |=> port_pin_o[2] == latch_q[2])
    else $error("latch value not at pin in state one phase one");
  alt_gate_a: assert property (enter_p1 |=> port_pin_o[4] == $past(latch_q[4] & compare_unit_outputs_i))
    else $error("alternate output not gated by latch");
  pullup_pulse_a: assert property (rise_on_p2_s |-> ##2 port_pin_oe_o[2][1] [*2] ##1 !port_pin_oe_o[2][1])
    else $error("strong pull-up not two periods");
  rmw_source_a: assert property (cpu_req_i && op_is_rmw(cpu_op_i) && latch_port |=>
    cpu_rdata_o == $past(latch_sel))
    else $error("modify read did not take the latch");
  pin_read_a: assert property (cpu_req_i && (cpu_op_i == port_pkg::OP_READ_PIN) |=>
    cpu_rdata_o == $past(pin_sel))
    else $error("plain read did not return pins");
  bit_only_a: assert property (load_now && do_write && (cpu_op_i == port_pkg::OP_SET_BIT) |=>
    ((latch_q[$past(cpu_port_i[2:0])] ^ $past(latch_sel)) & ~$past(bit_mask)) == 8'h00)
    else $error("bit operation touched other bits");
  reset_ones_a: assert property ($rose(reset_n_i) |-> latch_q == {7{8'hFF}})
    else $error("latches not all ones after reset");

endmodule : port_latch_pin_access

// file: testbench/port_pin_world.sv
`timescale 1ns/1ps

// Board around the ports: weak pull-ups on ports 1..6, a pull-up resistor on
// port 0, and outside drivers that can only pull a line low (wired-AND).
// Ports 7 and 8 are always driven from outside, so they never float here.
module port_pin_world (
  input  wire logic [6:0][7:0] pin_drive_i,
  input  wire logic [6:0][7:0] pin_oe_i,
  input  wire logic [8:0][7:0] ext_val_i,
  input  wire logic [8:0][7:0] ext_oe_i,
  output logic      [8:0][7:0] pins_o
);
  // Undriven lines rest high; the low side always wins a contention
  for (genvar p = 0; p < 7; p++) begin : g_bidir
    assign pins_o[p] = ((pin_oe_i[p] & pin_drive_i[p]) | ~pin_oe_i[p]) & ((ext_oe_i[p] & ext_val_i[p]) | ~ext_oe_i[p]);
  end
  // Input-only ports see only the outside source
  assign pins_o[7] = ext_val_i[7];
  assign pins_o[8] = ext_val_i[8];
endmodule : port_pin_world

// file: testbench/tb_port_latch_pin_access.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_port_latch_pin_access;
  logic clk_i = 1'b0;
  logic reset_n_i, cpu_req_i, cpu_carry_i, mc_phase2_o;
  logic [3:0] cpu_op_i, cpu_port_i;
  logic [2:0] cpu_bit_i;
  logic [7:0] cpu_operand_i, cpu_rdata_o, cmp_out, ccm_out;
  logic [5:0] mc_state_o;
  logic [8:0][7:0] pins, ext_val, ext_oe;
  logic [6:0][7:0] port_pin_o, port_pin_oe_o;
  logic clk_out, tx0, wr_s, rd_s, tx1;
  logic [6:0] p1_alt;
  logic [4:0] p3_alt;
  logic [1:0] p6_alt;
  logic tmr2_edge, t0_edge, tmr1_edge;
  int n_errors = 0;
  int compares = 0;
  int n_edge0 = 0;
  int n_edge1 = 0;
  int n_edge2 = 0;

  // 10 MHz clock; one clock is one phase
  always #50 clk_i = ~clk_i;

  // Count edge pulses of the timer inputs
  always @(posedge clk_i) begin
    if (t0_edge === 1'b1) n_edge0++;
    if (tmr1_edge === 1'b1) n_edge1++;
    if (tmr2_edge === 1'b1) n_edge2++;
  end

  port_latch_pin_access i_port_latch_pin_access (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cpu_req_i(cpu_req_i), .cpu_op_i(cpu_op_i),
    .cpu_port_i(cpu_port_i), .cpu_bit_i(cpu_bit_i), .cpu_operand_i(cpu_operand_i),
    .cpu_carry_i(cpu_carry_i), .cpu_rdata_o(cpu_rdata_o), .mc_state_o(mc_state_o),
    .mc_phase2_o(mc_phase2_o), .port_pin_i(pins), .port_pin_o(port_pin_o),
    .port_pin_oe_o(port_pin_oe_o), .system_clock_output_i(clk_out),
    .serial_zero_transmit_i(tx0), .ext_write_strobe_i(wr_s), .ext_read_strobe_i(rd_s),
    .compare_unit_outputs_i(cmp_out), .concurrent_compare_out_i(ccm_out),
    .serial_one_transmit_i(tx1), .irq3_capcomp0_pin_o(p1_alt[0]),
    .irq4_capcomp1_pin_o(p1_alt[1]), .irq5_capcomp2_pin_o(p1_alt[2]),
    .irq6_capcomp3_pin_o(p1_alt[3]), .irq2_capcomp4_pin_o(p1_alt[4]),
    .timer_two_reload_trigger_o(p1_alt[5]), .timer_two_count_in_o(p1_alt[6]),
    .timer_two_count_edge_o(tmr2_edge), .serial_zero_receive_o(p3_alt[0]),
    .ext_irq_zero_o(p3_alt[1]), .ext_irq_one_o(p3_alt[2]), .timer_zero_count_in_o(p3_alt[3]),
    .timer_zero_count_edge_o(t0_edge), .timer_one_count_in_o(p3_alt[4]),
    .timer_one_count_edge_o(tmr1_edge), .conversion_start_in_o(p6_alt[0]),
    .serial_one_receive_o(p6_alt[1])
  );

  port_pin_world i_port_pin_world (
    .pin_drive_i(port_pin_o), .pin_oe_i(port_pin_oe_o), .ext_val_i(ext_val),
    .ext_oe_i(ext_oe), .pins_o(pins)
  );

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // One core request placed in state 6 phase 1; returns at the falling edge in state 6 phase 2
  task automatic do_op(input logic [3:0] o, input logic [3:0] p, input logic [2:0] b,
                       input logic [7:0] d, input logic c);
    int n;
    n = 0;
    @(negedge clk_i);
    while (!(mc_state_o === port_pkg::ST_S6 && mc_phase2_o === 1'b0) && n < 30) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 30) n_errors++; // Sequencer never reached the slot
    cpu_req_i = 1'b1;
    cpu_op_i = o;
    cpu_port_i = p;
    cpu_bit_i = b;
    cpu_operand_i = d;
    cpu_carry_i = c;
    @(negedge clk_i);
    cpu_req_i = 1'b0;
  endtask : do_op

  // Hold pins steady for whole machine cycles so every level is sampled
  task automatic wait_mc(input int n);
    repeat (n * 12) @(negedge clk_i);
  endtask : wait_mc

  task automatic t_reset;
    `CHK(port_pin_oe_o, 56'h0)
    `CHK({p1_alt, p3_alt, p6_alt}, 14'h3FFF)
    do_op(port_pkg::OP_OR, 4'h1, 3'h0, 8'h00, 1'b0);
    `CHK(cpu_rdata_o, 8'hFF)
    `CHK({mc_state_o, mc_phase2_o}, 7'h41)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_write_timing;
    do_op(port_pkg::OP_WRITE, 4'h2, 3'h0, 8'h55, 1'b0);
    `CHK(port_pin_oe_o[2], 8'h00)
    @(negedge clk_i);
    `CHK(port_pin_oe_o[2], 8'hAA)
    `CHK(pins[2], 8'h55)
    do_op(port_pkg::OP_WRITE, 4'h2, 3'h0, 8'hAA, 1'b0);
    `CHK(port_pin_oe_o[2], 8'hAA)
    @(negedge clk_i);
    `CHK({port_pin_oe_o[2], port_pin_o[2]}, 16'hFFAA)
    @(negedge clk_i);
    `CHK(port_pin_oe_o[2], 8'hFF)
    @(negedge clk_i);
    `CHK(port_pin_oe_o[2], 8'h55)
    `CHK(pins[2], 8'hAA)
    $display("t_write_timing done");
  endtask : t_write_timing

  // Each modify op on port 4 returns the previous latch byte, never the pins
  task automatic t_rmw;
    logic [3:0] ops [11];
    logic [7:0] dat [11];
    logic [7:0] v;
    ops = '{port_pkg::OP_AND, port_pkg::OP_OR, port_pkg::OP_XOR, port_pkg::OP_JUMP_CLEAR,
            port_pkg::OP_FLIP_BIT, port_pkg::OP_INC, port_pkg::OP_MINUS_ONE, port_pkg::OP_LOOP_MINUS,
            port_pkg::OP_CARRY_BIT, port_pkg::OP_CLEAR_BIT, port_pkg::OP_SET_BIT};
    dat = '{8'h0F, 8'h30, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h05};
    ext_oe[4] = 8'hFF;
    ext_val[4] = 8'h00;
    do_op(port_pkg::OP_WRITE, 4'h4, 3'h0, 8'hC3, 1'b0);
    v = 8'hC3;
    for (int i = 0; i < 11; i++) begin
      do_op(ops[i], 4'h4, dat[i][2:0], dat[i], 1'b1);
      `CHK(cpu_rdata_o, v)
      case (ops[i])
        port_pkg::OP_AND: v = v & dat[i];
        port_pkg::OP_OR: v = v | dat[i];
        port_pkg::OP_XOR: v = v ^ dat[i];
        port_pkg::OP_FLIP_BIT: v[dat[i][2:0]] = ~v[dat[i][2:0]];
        port_pkg::OP_INC: v = v + 8'h01;
        port_pkg::OP_SET_BIT, port_pkg::OP_CARRY_BIT: v[dat[i][2:0]] = 1'b1;
        port_pkg::OP_MINUS_ONE, port_pkg::OP_LOOP_MINUS: v = v - 8'h01;
        default: v[dat[i][2:0]] = 1'b0;
      endcase
    end
    do_op(port_pkg::OP_OR, 4'h4, 3'h0, 8'h00, 1'b0);
    `CHK(cpu_rdata_o, v)
    $display("t_rmw done");
  endtask : t_rmw

  task automatic t_pin_read;
    do_op(port_pkg::OP_READ_PIN, 4'h4, 3'h0, 8'h00, 1'b0);
    `CHK(cpu_rdata_o, 8'h00)
    do_op(port_pkg::OP_WRITE, 4'h7, 3'h0, 8'h00, 1'b0);
    do_op(port_pkg::OP_READ_PIN, 4'h7, 3'h0, 8'h00, 1'b0);
    `CHK(cpu_rdata_o, 8'h5A)
    do_op(port_pkg::OP_OR, 4'h8, 3'h0, 8'h00, 1'b0);
    `CHK(cpu_rdata_o, 8'hC3)
    ext_oe[4] = 8'h00;
    // Port 0 is open drain: a latch one releases the line to the board pull-up
    do_op(port_pkg::OP_WRITE, 4'h0, 3'h0, 8'hF0, 1'b0);
    wait_mc(1);
    `CHK({port_pin_o[0], port_pin_oe_o[0], pins[0]}, 24'h000FF0)
    $display("t_pin_read done");
  endtask : t_pin_read

  task automatic t_alt_out;
    cmp_out = 8'h0F;
    ccm_out = 8'h3C;
    clk_out = 1'b0;
    do_op(port_pkg::OP_WRITE, 4'h4, 3'h0, 8'hFF, 1'b0);
    wait_mc(1);
    `CHK(pins[4], 8'h0F)
    `CHK(pins[5], 8'h3C)
    `CHK(pins[1], 8'hBF)
    do_op(port_pkg::OP_WRITE, 4'h4, 3'h0, 8'hF0, 1'b0);
    wait_mc(1);
    `CHK(pins[4], 8'h00)
    $display("t_alt_out done");
  endtask : t_alt_out

  task automatic t_alt_in;
    n_edge0 = 0;
    n_edge1 = 0;
    n_edge2 = 0;
    ext_oe[1] = 8'hFF;
    ext_val[1] = 8'h5A;
    ext_oe[3] = 8'h3D;
    ext_val[3] = 8'hA5;
    ext_oe[6] = 8'h03;
    ext_val[6] = 8'h02;
    wait_mc(3);
    `CHK(p1_alt, 7'h1A)
    `CHK(p3_alt, 5'h13)
    `CHK(p6_alt, 2'h2)
    `CHK(n_edge0, 1)
    `CHK(n_edge1, 0)
    `CHK(n_edge2, 1)
    ext_val[3][4] = 1'b1;
    wait_mc(3);
    `CHK(n_edge0, 2)
    $display("t_alt_in done");
  endtask : t_alt_in

  // Watchdog: the tests need well under two thousand clocks
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    report_and_stop();
  end

  initial begin
    reset_n_i = 1'b0;
    cpu_req_i = 1'b0;
    cpu_op_i = 4'h0;
    cpu_port_i = 4'h0;
    cpu_bit_i = 3'h0;
    cpu_operand_i = 8'h00;
    cpu_carry_i = 1'b0;
    {clk_out, tx0, wr_s, rd_s, tx1} = 5'h1F;
    cmp_out = port_pkg::NO_ALT_OUT;
    ccm_out = port_pkg::NO_ALT_OUT;
    ext_val = '1;
    ext_oe = '0;
    ext_val[7] = 8'h5A;
    ext_val[8] = 8'hC3;
    repeat (3) @(negedge clk_i);
    reset_n_i = 1'b1;
    wait_mc(2);
    t_reset();
    t_write_timing();
    t_rmw();
    t_pin_read();
    t_alt_out();
    t_alt_in();
    report_and_stop();
  end
endmodule : tb_port_latch_pin_access
